// file: smc_pkg.sv
// package: register map, fields, reset values and types of the standby-mode controller
package smc_pkg;
  // register byte offsets
  localparam logic [7:0] PWR_CTL_OFS = 8'h00;
  localparam logic [7:0] MODE_SEL_OFS = 8'h04;
  localparam logic [7:0] STAB_SEL_OFS = 8'h08;
  localparam logic [7:0] FILT_CTL_OFS = 8'h0c;
  localparam logic [7:0] STAT_OFS = 8'h10;
  // power_save_control_reg fields
  localparam int ENTRY_BIT = 1;
  localparam int WMASK_INT_BIT = 4;
  localparam int WMASK_NM0_BIT = 5;
  localparam int WMASK_NM1_BIT = 6;
  // save_mode_select_reg fields and encodings
  localparam int MODE_SEL_LSB = 0;
  localparam logic [1:0] MODE_IDLE_ONE = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  // osc_stabilize_time_select
  localparam int STAB_SEL_W = 3;
  localparam logic [2:0] STAB_SEL_RESET = 3'h6;
  localparam logic [2:0] STAB_SEL_MAX = 3'h6;
  localparam int OST_BASE_LOG2 = 10;
  // noise_filter_control_reg fields
  localparam int FILT_EN_BIT = 7;
  localparam int FILT_SEL_LSB = 0;
  localparam logic [2:0] FILT_SLOW_MIN = 3'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic nmi1;
    logic nmi0;
    logic maskable;
    logic extPin3;
  } smc_wake_t;

  typedef struct packed {
    logic cpuClkEn;
    logic periphClkEn;
    logic oscEn;
  } smc_clk_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_HALT,
    ST_IDLE_ONE,
    ST_STOP,
    ST_OSC_START,
    ST_STABILIZE
  } smc_state_t;
endpackage

// file: smc_standby_ctrl.sv
// standby-mode controller: halt, idle-1, stop and oscillation stabilization wait
// Function
// R1: mode select field acts only while the standby-entry bit is one.
// R2: stabilization count starts only once the oscillator is running.
// R3: software writes zero to reserved bits 3..7 of the stabilization select.
// R4: stabilization select resets to 06h, giving 2^16 oscillator periods after reset.
// R5: software places five no-ops after the halt instruction.
// R6: halt with a pending unmasked request enters halt, then leaves at once.
// R7: software follows the idle-1 store with five no-ops.
// R8: idle-1 set with a pending unmasked request is released immediately.
// R9: a request class masked by its wake mask bit does not release idle-1.
// R10: pin-3 request with slow noise filter sampling does not release idle-1.
// R11: software programs mode select bits before setting the standby-entry bit.
// R12: wake mask bits written with the standby-entry bit set are ignored.
// R13: after stop wait, processor clock restarts and the waking interrupt is vectored.
`timescale 1ns/1ps
module smc_standby_ctrl #(
  parameter int OstBaseLog2 = smc_pkg::OST_BASE_LOG2
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // processor core
  input wire logic haltReq,
  output smc_pkg::smc_clk_t clkCtl,
  output logic wakeVector,
  // interrupt sources and oscillator
  input smc_pkg::smc_wake_t wakeReq,
  input wire logic oscRunning
);
  smc_pkg::smc_state_t state_q;
  logic standbyEntry_q;
  logic [1:0] psmSel_q;
  logic intMask_q;
  logic nmi0Mask_q;
  logic nmi1Mask_q;
  logic [2:0] stabSel_q;
  logic filtEn_q;
  logic [2:0] filtSel_q;
  logic [23:0] stabCnt_q;
  logic wokeByIrq_q;
  logic wakeVector_q;
  smc_pkg::smc_clk_t clkCtl_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // wake qualification
  logic pin3Filtered;
  logic wakeMasked;
  logic wakeAny;
  logic wrTake;
  logic entryWrite;
  logic [2:0] stabSelEff;
  logic [23:0] stabLast;

  assign pin3Filtered = filtEn_q && (filtSel_q >= smc_pkg::FILT_SLOW_MIN); // [R10]
  assign wakeMasked = (wakeReq.nmi1 && !nmi1Mask_q) // [R9]
    || (wakeReq.nmi0 && !nmi0Mask_q)
    || (wakeReq.maskable && !intMask_q)
    || (wakeReq.extPin3 && !intMask_q && !pin3Filtered); // [R10]
  // halt ignores the wake masks
  assign wakeAny = wakeReq.nmi1 || wakeReq.nmi0 || wakeReq.maskable || wakeReq.extPin3;
  assign wrTake = awready_q && wready_q;
  assign entryWrite = wrTake && (awaddr == smc_pkg::PWR_CTL_OFS) && wstrb[0] && wdata[smc_pkg::ENTRY_BIT];
  assign stabSelEff = (stabSel_q > smc_pkg::STAB_SEL_MAX) ? smc_pkg::STAB_SEL_MAX : stabSel_q;
  assign stabLast = 24'((32'h1 << (OstBaseLog2 + 32'(stabSelEff))) - 32'h1); // [R4]

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= smc_pkg::RESP_OKAY;
    end
    else
    begin
      awready_q <= awvalid && wvalid && !bvalid_q && !awready_q;
      wready_q <= awvalid && wvalid && !bvalid_q && !awready_q;
      if (wrTake)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= (awaddr == smc_pkg::PWR_CTL_OFS || awaddr == smc_pkg::MODE_SEL_OFS
          || awaddr == smc_pkg::STAB_SEL_OFS || awaddr == smc_pkg::FILT_CTL_OFS
          || awaddr == smc_pkg::STAT_OFS) ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      psmSel_q <= smc_pkg::MODE_IDLE_ONE;
      intMask_q <= 1'b0;
      nmi0Mask_q <= 1'b0;
      nmi1Mask_q <= 1'b0;
      stabSel_q <= smc_pkg::STAB_SEL_RESET; // [R4]
      filtEn_q <= 1'b0;
      filtSel_q <= 3'h0;
    end
    else if (wrTake && wstrb[0])
    begin
      if (awaddr == smc_pkg::PWR_CTL_OFS && !wdata[smc_pkg::ENTRY_BIT])
      begin
        // masks set together with the standby-entry bit are dropped
        intMask_q <= wdata[smc_pkg::WMASK_INT_BIT]; // [R12]
        nmi0Mask_q <= wdata[smc_pkg::WMASK_NM0_BIT];
        nmi1Mask_q <= wdata[smc_pkg::WMASK_NM1_BIT];
      end
      if (awaddr == smc_pkg::MODE_SEL_OFS)
      begin
        psmSel_q <= wdata[smc_pkg::MODE_SEL_LSB +: 2];
      end
      if (awaddr == smc_pkg::STAB_SEL_OFS)
      begin
        stabSel_q <= wdata[smc_pkg::STAB_SEL_W-1:0];
      end
      if (awaddr == smc_pkg::FILT_CTL_OFS)
      begin
        filtEn_q <= wdata[smc_pkg::FILT_EN_BIT];
        filtSel_q <= wdata[smc_pkg::FILT_SEL_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // standby sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= smc_pkg::ST_OSC_START;
      standbyEntry_q <= 1'b0;
      stabCnt_q <= 24'h0;
      wokeByIrq_q <= 1'b0;
      wakeVector_q <= 1'b0;
    end
    else
    begin
      wakeVector_q <= 1'b0;
      unique case (state_q)
        smc_pkg::ST_RUN:
        begin
          if (entryWrite)
          begin
            // mode field only consulted here, under the entry bit
            if (psmSel_q == smc_pkg::MODE_IDLE_ONE) // [R1]
            begin
              standbyEntry_q <= 1'b1;
              state_q <= smc_pkg::ST_IDLE_ONE;
            end
            else if (psmSel_q == smc_pkg::MODE_STOP) // [R1]
            begin
              standbyEntry_q <= 1'b1;
              state_q <= smc_pkg::ST_STOP;
            end
          end
          else if (haltReq)
          begin
            state_q <= smc_pkg::ST_HALT; // [R6]
          end
        end
        smc_pkg::ST_HALT:
        begin
          if (wakeAny)
          begin
            state_q <= smc_pkg::ST_RUN; // [R6]
            wakeVector_q <= 1'b1;
          end
        end
        smc_pkg::ST_IDLE_ONE:
        begin
          if (wakeMasked)
          begin
            state_q <= smc_pkg::ST_RUN; // [R8]
            standbyEntry_q <= 1'b0;
            wakeVector_q <= 1'b1;
          end
        end
        smc_pkg::ST_STOP:
        begin
          if (wakeMasked)
          begin
            state_q <= smc_pkg::ST_OSC_START;
            wokeByIrq_q <= 1'b1;
          end
        end
        smc_pkg::ST_OSC_START:
        begin
          stabCnt_q <= 24'h0;
          if (oscRunning)
          begin
            state_q <= smc_pkg::ST_STABILIZE; // [R2]
          end
        end
        smc_pkg::ST_STABILIZE:
        begin
          if (stabCnt_q == stabLast)
          begin
            state_q <= smc_pkg::ST_RUN; // [R13]
            standbyEntry_q <= 1'b0;
            wokeByIrq_q <= 1'b0;
            wakeVector_q <= wokeByIrq_q; // [R13]
          end
          else
          begin
            stabCnt_q <= stabCnt_q + 24'h1; // [R2]
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock gating outputs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clkCtl_q <= '{cpuClkEn: 1'b0, periphClkEn: 1'b0, oscEn: 1'b1};
    end
    else
    begin
      clkCtl_q.cpuClkEn <= (state_q == smc_pkg::ST_RUN) && !entryWrite && !haltReq; // [R13]
      clkCtl_q.periphClkEn <= (state_q == smc_pkg::ST_RUN) || (state_q == smc_pkg::ST_HALT);
      clkCtl_q.oscEn <= (state_q != smc_pkg::ST_STOP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= smc_pkg::RESP_OKAY;
    end
    else
    begin
      arready_q <= arvalid && !rvalid_q && !arready_q;
      if (arready_q)
      begin
        rvalid_q <= 1'b1;
        rresp_q <= smc_pkg::RESP_OKAY;
        rdata_q <= 32'h0;
        unique case (araddr)
          smc_pkg::PWR_CTL_OFS:
          begin
            rdata_q[smc_pkg::ENTRY_BIT] <= standbyEntry_q;
            rdata_q[smc_pkg::WMASK_INT_BIT] <= intMask_q;
            rdata_q[smc_pkg::WMASK_NM0_BIT] <= nmi0Mask_q;
            rdata_q[smc_pkg::WMASK_NM1_BIT] <= nmi1Mask_q;
          end
          smc_pkg::MODE_SEL_OFS: rdata_q[smc_pkg::MODE_SEL_LSB +: 2] <= psmSel_q;
          smc_pkg::STAB_SEL_OFS: rdata_q[smc_pkg::STAB_SEL_W-1:0] <= stabSel_q; // [R3]
          smc_pkg::FILT_CTL_OFS:
          begin
            rdata_q[smc_pkg::FILT_EN_BIT] <= filtEn_q;
            rdata_q[smc_pkg::FILT_SEL_LSB +: 3] <= filtSel_q;
          end
          smc_pkg::STAT_OFS: rdata_q[2:0] <= 3'(state_q);
          default: rresp_q <= smc_pkg::RESP_SLVERR;
        endcase
      end
      else if (rready)
      begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign clkCtl = clkCtl_q;
  assign wakeVector = wakeVector_q;
endmodule

// file: smc_standby_ctrl_props.sv
// checker: port-level assertions of the standby-mode controller
`timescale 1ns/1ps
module smc_standby_ctrl_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic awready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // core and wake side
  input wire logic haltReq,
  input smc_pkg::smc_clk_t clkCtl,
  input wire logic wakeVector,
  input smc_pkg::smc_wake_t wakeReq,
  input wire logic oscRunning
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence haltPend;
    haltReq && (|wakeReq) && clkCtl.cpuClkEn;
  endsequence
  sequence wakeThenRun;
    ##1 !wakeVector ##[0:1] clkCtl.cpuClkEn;
  endsequence
  chk_halt_pend: assert property (haltPend |-> ##[1:4] wakeVector)
    else $error("halt with pending request not left");
  chk_wake_run: assert property ($rose(wakeVector) |-> wakeThenRun)
    else $error("core clock not restarted after wake");
  chk_run_osc: assert property (clkCtl.cpuClkEn |-> oscRunning)
    else $error("core clock on without oscillator");
  chk_wait_osc: assert property ($rose(clkCtl.cpuClkEn) |-> $past(oscRunning, 4))
    else $error("wait counted before oscillator ran");
  chk_stop_nocpu: assert property (!clkCtl.oscEn |-> !clkCtl.cpuClkEn)
    else $error("core clock on while oscillator stopped");
  chk_wr_resp: assert property (awready |=> bvalid)
    else $error("write response missing");
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_rd_resp: assert property (arready |=> rvalid)
    else $error("read data missing");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule

bind smc_standby_ctrl smc_standby_ctrl_props chk_u (.mclk, .rst, .awready, .bresp, .bvalid, .bready, .arready,
  .rdata, .rvalid, .rready, .haltReq, .clkCtl, .wakeVector, .wakeReq, .oscRunning);

// file: smc_irq_osc_model.sv
// partner: interrupt request sources and main oscillator start-up
`timescale 1ns/1ps
module smc_irq_osc_model #(
  parameter int OscDly = 20
)(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // from controller
  input wire logic oscEn,
  // from bench
  input smc_pkg::smc_wake_t reqSet,
  // to controller
  output smc_pkg::smc_wake_t wakeReq,
  output logic oscRunning
);
  int cnt;
  // requests stay pending until the source withdraws them
  assign wakeReq = reqSet;
  // start-up interval after enable, stops at once when disabled
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      cnt <= 0;
      oscRunning <= 1'b0;
    end
    else
    begin
      cnt <= oscEn ? cnt + int'(cnt < OscDly) : 0;
      oscRunning <= oscEn && cnt == OscDly;
    end
endmodule

// file: tb.sv
// testbench: register bus, standby modes and stabilization wait
`timescale 1ns/1ps
module tb;
  localparam int Base = 2;
  localparam logic [7:0] PwrCtl = smc_pkg::PWR_CTL_OFS;
  localparam logic [7:0] ModeSel = smc_pkg::MODE_SEL_OFS;
  localparam logic [7:0] StabSel = smc_pkg::STAB_SEL_OFS;
  logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, haltReq = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid, wakeVector, oscRunning;
  logic [1:0] bresp, rresp;
  smc_pkg::smc_clk_t clkCtl;
  smc_pkg::smc_wake_t wakeReq, reqSet = 0;
  logic [33:0] expQ[$];
  int errTotal = 0, compares = 0, wakes = 0, mark, n, stabSel;
  always #2.5 mclk = ~mclk;
  smc_standby_ctrl #(.OstBaseLog2(Base)) dut_u (.mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .haltReq, .clkCtl, .wakeVector, .wakeReq, .oscRunning);
  smc_irq_osc_model irq_u (.mclk, .rst, .oscEn(clkCtl.oscEn), .reqSet, .wakeReq, .oscRunning);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      errTotal++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    chk({32'h0, bresp}, {32'h0, e});
    bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    expQ.push_back(e);
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic st(input logic [2:0] s);
    rd(smc_pkg::STAT_OFS, {31'h0, s});
  endtask
  task automatic enter(input logic [31:0] sel, input logic [31:0] d);
    wr(ModeSel, sel);
    mark = wakes;
    wr(PwrCtl, d);
  endtask
  task automatic seen(input int w, input int e);
    repeat (w) @(posedge mclk);
    chk(34'(wakes - mark), 34'(e));
  endtask
  task automatic testDone;
    $display("compares=%0d mismatches=%0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge mclk)
  begin
    if (wakeVector === 1'b1)
      wakes <= wakes + 1;
    if (rvalid === 1'b1 && rready === 1'b1)
      chk({rresp, rdata}, expQ.pop_front());
  end
  initial
  begin
    #100000;
    errTotal++;
    testDone;
  end
  initial
  begin
    void'($urandom(58400));
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    do @(posedge mclk); while (oscRunning !== 1'b1);
    for (n = 0; clkCtl.cpuClkEn !== 1'b1; n++) @(posedge mclk);
    chk(34'(n >= (1 << (Base + 6)) && n <= (1 << (Base + 6)) + 4), 34'h1);
    rd(StabSel, 34'h6);
    rd(8'h14, {smc_pkg::RESP_SLVERR, 32'h0});
    wr(8'h14, 32'h0, smc_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(ModeSel, 32'h1);
    wr(PwrCtl, 32'h0);
    st(3'h0);
    enter(32'h2, 32'h2);
    st(3'h0);
    reqSet <= 4'h2;
    enter(32'h0, 32'h12);
    seen(20, 1);
    $display("test mode select done");
    for (int i = 0; i < 3; i++)
    begin
      reqSet <= 4'h0;
      wr(PwrCtl, 32'h10 << i);
      reqSet <= 4'(2 << i);
      enter(32'h0, 32'h2);
      seen(20, 0);
      st(3'h2);
      chk(34'({clkCtl.cpuClkEn, clkCtl.periphClkEn, clkCtl.oscEn}), 34'h1);
      reqSet <= 4'(2 << ((i + 1) % 3));
      seen(20, 1);
      wr(PwrCtl, 32'h0);
    end
    $display("test wake masks done");
    reqSet <= 4'h1;
    wr(smc_pkg::FILT_CTL_OFS, 32'h80 | (3 + $urandom % 5));
    enter(32'h0, 32'h2);
    seen(20, 0);
    reqSet <= 4'h3;
    seen(20, 1);
    reqSet <= 4'h8;
    mark = wakes;
    haltReq <= 1'b1;
    @(posedge mclk);
    haltReq <= 1'b0;
    seen(10, 1);
    $display("test filter and halt done");
    reqSet <= 4'h0;
    stabSel = $urandom % 7;
    wr(StabSel, 32'(stabSel));
    rd(StabSel, 34'(stabSel));
    enter(32'h1, 32'h2);
    st(3'h3);
    chk(34'({clkCtl.cpuClkEn, clkCtl.oscEn}), 34'h0);
    reqSet <= 4'h8;
    for (n = 0; wakes == mark && n < 600; n++) @(posedge mclk);
    chk(34'(n >= 20 + (1 << (Base + stabSel)) && n <= 30 + (1 << (Base + stabSel))), 34'h1);
    repeat (3) @(posedge mclk);
    chk(34'(clkCtl.cpuClkEn), 34'h1);
    reqSet <= 4'h0;
    $display("test stop release done");
    testDone;
  end
endmodule
